// ### sim/tb_top.sv
// Self-checking bench for the video memory map and clear top.
// Assumes the host model drives all port cycles on falling edges.
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sixteen_lines = 1'b0;
  vrc_pkg::vrc_io_req_t io_req;
  vrc_pkg::vrc_mem_cmd_t cpu_mem_cmd, video_memory_cmd;
  logic [7:0] io_rdata, pixel_shift, scroll_latch, rd;
  logic cpu_mem_req, cpu_mem_grant, screen_fill_request_n, fill_busy, frame_done;
  logic [2:0] video_memory_plane_we;
  logic [13:0] display_start;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  int seen;
  always #25 core_clk = ~core_clk;
  vrc_host_model host (.core_clk(core_clk), .io_rdata(io_rdata), .io_req(io_req),
    .cpu_mem_req(cpu_mem_req), .cpu_mem_cmd(cpu_mem_cmd));
  vrc_video_map #(.FRAME_CYCLES(100)) DUT (.core_clk(core_clk), .reset_n(reset_n),
    .io_req(io_req), .io_rdata(io_rdata), .cpu_mem_req(cpu_mem_req),
    .cpu_mem_cmd(cpu_mem_cmd), .cpu_mem_grant(cpu_mem_grant),
    .sixteen_lines(sixteen_lines), .video_memory_cmd(video_memory_cmd),
    .video_memory_plane_we(video_memory_plane_we), .pixel_shift(pixel_shift),
    .display_start(display_start), .scroll_latch(scroll_latch),
    .screen_fill_request_n(screen_fill_request_n), .fill_busy(fill_busy),
    .frame_done(frame_done));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_chk(input logic [7:0] p, input logic [7:0] e);
    host.io_read(p, rd);
    check({8'h00, rd}, {8'h00, e});
  endtask
  task automatic test_done();
    $display("Compares %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic run_clear(input logic [7:0] fill, input int len);
    host.io_write(8'hdb, (fill == 8'hff) ? 8'h0f : 8'h07);
    host.io_write(8'hd9, 8'hf7);
    reg_chk(8'hd9, 8'hf7);
    @(negedge core_clk);
    check(16'(video_memory_plane_we), 16'h0007);
    check(16'(video_memory_cmd.data), 16'(fill));
    check(16'(pixel_shift), 16'(fill));
    check(16'(cpu_mem_grant), 16'h0000);
    // hold one whole frame.
    // Any span of one frame of cycles visits every scanned byte and holds one frame pulse.
    n = 0;
    seen = 0;
    while (n < len) begin
      @(negedge core_clk);
      n++;
      if (frame_done === 1'b1) seen++;
    end
    check(16'(seen), 16'h0001);
    host.io_write(8'hd9, 8'hff);
    @(negedge core_clk);
    check(16'(video_memory_plane_we), 16'h0000);
    $display("Clear test done, fill %h", fill);
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    reg_chk(8'hd9, 8'h08);
    reg_chk(8'hdb, 8'h00);
    check(16'(screen_fill_request_n), 16'h0001);
    host.io_write(8'hdc, 8'h0c);
    host.io_write(8'hdd, 8'hff);
    reg_chk(8'hdd, 8'h3f);
    host.io_write(8'hdc, 8'h0d);
    host.io_write(8'hdd, 8'h50);
    check(16'(display_start), 16'h3f50);
    // latch holds the byte written to port DA, here equal to start bits eleven to four.
    host.io_write(8'hda, 8'hf5);
    check(16'(scroll_latch), 16'h00f5);
    host.io_write(8'hdc, 8'h12);
    host.io_write(8'hdd, 8'h5a);
    reg_chk(8'hdd, 8'h00);
    $display("Register test done");
    run_clear(8'h00, 80 * 9 * 25);
    // Line mode changes only under reset so the scan never sees a half row.
    reset_n = 1'b0;
    sixteen_lines = 1'b1;
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    run_clear(8'hff, 80 * 16 * 25);
    test_done();
  end
  // The tests need about 50,100 cycles, so 90,000 cycles means a hang.
  initial begin
    #(90000 * 50);
    fail_count++;
    test_done();
  end
endmodule

bind vrc_video_map vrc_video_map_props #(.FRAME_CYCLES(FRAME_CYCLES)) u_props (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .io_req(io_req),
  .io_rdata(io_rdata),
  .cpu_mem_req(cpu_mem_req),
  .cpu_mem_grant(cpu_mem_grant),
  .sixteen_lines(sixteen_lines),
  .video_memory_cmd(video_memory_cmd),
  .video_memory_plane_we(video_memory_plane_we),
  .screen_fill_request_n(screen_fill_request_n),
  .fill_busy(fill_busy),
  .frame_done(frame_done)
);

// ### sim/vrc_host_model.sv
// Host processor model issuing I/O port cycles and one memory request.
// Assumes the bench calls its tasks; requests change on the falling edge.
`timescale 1ns/1ps
module vrc_host_model (
  input wire logic core_clk,
  input wire logic [7:0] io_rdata,
  output vrc_pkg::vrc_io_req_t io_req,
  output logic cpu_mem_req,
  output vrc_pkg::vrc_mem_cmd_t cpu_mem_cmd
);
  // legal byte only. The request stays up because grants may never come.
  initial begin
    io_req = '0;
    cpu_mem_req = 1'b1;
    cpu_mem_cmd = '{addr: 16'h0010, data: 8'h5a, we: 1'b0};
  end
  task automatic io_write(input logic [7:0] p, input logic [7:0] d);
    @(negedge core_clk);
    io_req = '{sel: 1'b1, wr: 1'b1, port: p, wdata: d};
    @(negedge core_clk);
    io_req = '{sel: 1'b0, wr: 1'b0, port: ~p, wdata: ~d};
  endtask
  task automatic io_read(input logic [7:0] p, output logic [7:0] d);
    @(negedge core_clk);
    io_req = '{sel: 1'b1, wr: 1'b0, port: p, wdata: 8'h00};
    @(negedge core_clk);
    d = io_rdata;
    io_req = '{sel: 1'b0, wr: 1'b0, port: ~p, wdata: 8'hff};
  endtask
endmodule

// ### sim/vrc_video_map_props.sv
// Port checks for the video memory map and clear top.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module vrc_video_map_props #(
  parameter int FRAME_CYCLES = 100
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire vrc_pkg::vrc_io_req_t io_req,
  input wire logic [7:0] io_rdata,
  input wire logic cpu_mem_req,
  input wire logic cpu_mem_grant,
  input wire logic sixteen_lines,
  input wire vrc_pkg::vrc_mem_cmd_t video_memory_cmd,
  input wire logic [2:0] video_memory_plane_we,
  input wire logic screen_fill_request_n,
  input wire logic fill_busy,
  input wire logic frame_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // The longest frame is sixteen lines of 25 rows of 80 bytes.
  logic [15:0] gap;
  always_ff @(posedge core_clk) begin
    if (!reset_n || frame_done) gap <= 16'h0000;
    else gap <= gap + 16'h0001;
  end
  sequence s_clear_start;
    $fell(screen_fill_request_n);
  endsequence
  a_fill_all_planes: assert property (
    !screen_fill_request_n |-> video_memory_plane_we == 3'b111 && video_memory_cmd.we)
    else $error("fill does not write all planes");
  a_idle_no_fill: assert property (screen_fill_request_n |-> video_memory_plane_we == 3'b000)
    else $error("plane write while clear inactive");
  a_fill_value_set: assert property (
    !screen_fill_request_n |-> video_memory_cmd.data inside {8'h00, 8'hff})
    else $error("fill value neither 00 nor ff");
  a_busy_follows_clear: assert property (s_clear_start |=> fill_busy)
    else $error("busy missing after clear start");
  a_frame_single: assert property (frame_done |=> !frame_done)
    else $error("frame pulse too long");
  // The first frame after reset also counts the cycle parked at byte zero, so it reaches 32000.
  a_frame_bound: assert property (gap <= 16'h7d00)
    else $error("frame longer than its scan");
  a_scan_bytes: assert property (video_memory_cmd.addr[6:0] <= 7'h4f)
    else $error("scan visits a hole byte");
  a_nine_hidden: assert property (!sixteen_lines |-> video_memory_cmd.addr[10:7] <= 4'h8)
    else $error("hidden scan line displayed");
  a_grant_cause: assert property (cpu_mem_grant |-> cpu_mem_req)
    else $error("grant without request");
  a_read_stands: assert property (!(io_req.sel && !io_req.wr) |=> $stable(io_rdata))
    else $error("read data changed without read");
endmodule

// ### verilog/vrc_arbiter.sv
// Video memory port arbiter: display fetches win, CPU waits, fill writes ride on fetch slots.
// Assumes a single-cycle memory port shared by all three planes.
`timescale 1ns/1ps
`include "vrc_defines.svh"
module vrc_arbiter (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic display_req,
  input wire logic [15:0] display_addr,
  input wire logic fill_active,
  input wire logic [7:0] fill_data,
  input wire logic cpu_req,
  input wire vrc_pkg::vrc_mem_cmd_t cpu_cmd,
  output logic cpu_grant,
  output vrc_pkg::vrc_mem_cmd_t mem_cmd,
  output logic [2:0] fill_planes_we
);
  typedef struct packed {
    logic cpu_pending;
  } vrc_arb_state_t;

  vrc_arb_state_t state;
  vrc_arb_state_t next_state;

  always_comb begin
    next_state = state;
    mem_cmd = '0;
    fill_planes_we = 3'b000;
    cpu_grant = 1'b0;
    if (display_req) begin
      mem_cmd.addr = display_addr;
      if (fill_active) begin
        mem_cmd.data = fill_data;
        mem_cmd.we = 1'b1;
        fill_planes_we = 3'b111;
      end
      next_state.cpu_pending = cpu_req;
    end else if (cpu_req) begin
      mem_cmd = cpu_cmd;
      cpu_grant = 1'b1;
      next_state.cpu_pending = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

// ### verilog/vrc_defines.svh
// Port addresses, field positions and timing counts of the video memory map and clear block.
// Included by the package and every design file; holds definitions only.
`ifndef VRC_DEFINES_SVH
`define VRC_DEFINES_SVH
`define VRC_PORT_CLEAR_A 8'hd9
`define VRC_PORT_LATCH 8'hda
`define VRC_PORT_FILL_B 8'hdb
`define VRC_PORT_POINTER 8'hdc
`define VRC_PORT_WINDOW 8'hdd
`define VRC_CTRL_REG_COUNT 18
`define VRC_IDX_START_HIGH 5'h0c
`define VRC_IDX_START_LOW 5'h0d
`define VRC_START_HIGH_MASK 8'h3f
`define VRC_CLEAR_BIT 3
`define VRC_FILL_BIT 3
`define VRC_PORT_A_RESET 8'h08
`define VRC_PORT_B_RESET 8'h00
`define VRC_BYTES_PER_LINE 7'h50
`define VRC_LAST_BYTE 7'h4f
`define VRC_NINE_LAST_SCAN 4'h8
`define VRC_SIXTEEN_LAST_SCAN 4'hf
`define VRC_ROWS 5'h19
`define VRC_FRAME_TIME_US 16700
`define VRC_CLK_MHZ 20
`define VRC_FRAME_CYCLES ((`VRC_FRAME_TIME_US * `VRC_CLK_MHZ))
`endif

// ### verilog/vrc_pkg.sv
// Types shared by the video memory map and clear block.
// Assumes vrc_defines.svh sits on the include path.
package vrc_pkg;
  `include "vrc_defines.svh"

  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] port;
    logic [7:0] wdata;
  } vrc_io_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic we;
  } vrc_mem_cmd_t;

  typedef struct packed {
    logic [2:0] plane_we;
    logic [7:0] data;
  } vrc_fill_cmd_t;
endpackage

// ### verilog/vrc_scan_gen.sv
// Display scan address generator: walks bytes, scan lines and rows from the start address.
// Assumes one byte fetch per clock; blanking and sync are outside this block.
`timescale 1ns/1ps
`include "vrc_defines.svh"
module vrc_scan_gen (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [13:0] start_address,
  input wire logic sixteen_lines,
  output logic [15:0] scan_addr,
  output logic frame_end
);
  typedef struct packed {
    logic [6:0] col;
    logic [3:0] scan;
    logic [4:0] row;
  } vrc_scan_state_t;

  vrc_scan_state_t state;
  vrc_scan_state_t next_state;
  logic [3:0] last_scan;
  logic [8:0] line_addr;

  // Nine-line rows skip scan values 9 to F so the screen stays continuous.
  // scan 9 to F unfetched.
  assign last_scan = sixteen_lines ? `VRC_SIXTEEN_LAST_SCAN : `VRC_NINE_LAST_SCAN;
  assign line_addr = 9'(start_address[13:4] + {5'h00, state.row}) << 4 | 9'(state.scan);
  assign scan_addr = {line_addr, state.col};
  assign frame_end = (state.col == `VRC_LAST_BYTE) && (state.scan == last_scan)
                     && (state.row == 5'(`VRC_ROWS - 1));

  always_comb begin
    next_state = state;
    if (state.col == `VRC_LAST_BYTE) begin
      next_state.col = 7'h00;
      if (state.scan == last_scan) begin
        next_state.scan = 4'h0;
        next_state.row = frame_end ? 5'h00 : 5'(state.row + 5'h01);
      end else begin
        next_state.scan = 4'(state.scan + 4'h1);
      end
    end else begin
      next_state.col = 7'(state.col + 7'h01);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

// ### verilog/vrc_video_map.sv
// Top of the video memory map and clear block: I/O ports, controller window, scan, clear.
// Assumes the host issues one-cycle I/O strobes and holds memory requests until granted.
`timescale 1ns/1ps
`include "vrc_defines.svh"
module vrc_video_map #(
  parameter int FRAME_CYCLES = `VRC_FRAME_CYCLES,
  parameter int CTRL_REGS = `VRC_CTRL_REG_COUNT
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire vrc_pkg::vrc_io_req_t io_req,
  output logic [7:0] io_rdata,
  input wire logic cpu_mem_req,
  input wire vrc_pkg::vrc_mem_cmd_t cpu_mem_cmd,
  output logic cpu_mem_grant,
  input wire logic sixteen_lines,
  output vrc_pkg::vrc_mem_cmd_t video_memory_cmd,
  output logic [2:0] video_memory_plane_we,
  output logic [7:0] pixel_shift,
  output logic [13:0] display_start,
  output logic [7:0] scroll_latch,
  output logic screen_fill_request_n,
  output logic fill_busy,
  output logic frame_done
);
  typedef struct packed {
    logic [7:0] port_a;
    logic [7:0] port_b;
    logic [7:0] latch;
    logic [4:0] pointer;
    logic [7:0] rdata;
    logic [7:0] shift;
    logic fill_run;
    logic [31:0] fill_count;
    logic frame_pulse;
  } vrc_top_state_t;

  vrc_top_state_t state;
  vrc_top_state_t next_state;
  logic [7:0] ctrl_regs [CTRL_REGS];
  logic [15:0] scan_addr;
  logic frame_end;
  logic clear_active;
  logic [7:0] fill_value;
  logic wr_window;
  logic [4:0] ptr;

  assign display_start = {ctrl_regs[`VRC_IDX_START_HIGH][5:0], ctrl_regs[`VRC_IDX_START_LOW]};
  assign clear_active = !state.port_a[`VRC_CLEAR_BIT];
  assign fill_value = state.port_b[`VRC_FILL_BIT] ? 8'hff : 8'h00;
  assign screen_fill_request_n = state.port_a[`VRC_CLEAR_BIT];
  assign scroll_latch = state.latch;
  assign io_rdata = state.rdata;
  assign pixel_shift = state.shift;
  assign fill_busy = state.fill_run;
  assign frame_done = state.frame_pulse;
  assign ptr = state.pointer;
  assign wr_window = io_req.sel && io_req.wr && (io_req.port == `VRC_PORT_WINDOW);

  vrc_scan_gen u_scan (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start_address(display_start),
    .sixteen_lines(sixteen_lines),
    .scan_addr(scan_addr),
    .frame_end(frame_end)
  );

  vrc_arbiter u_arb (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .display_req(1'b1),
    .display_addr(scan_addr),
    .fill_active(clear_active),
    .fill_data(fill_value),
    .cpu_req(cpu_mem_req),
    .cpu_cmd(cpu_mem_cmd),
    .cpu_grant(cpu_mem_grant),
    .mem_cmd(video_memory_cmd),
    .fill_planes_we(video_memory_plane_we)
  );

  genvar gi;
  generate
    for (gi = 0; gi < CTRL_REGS; gi++) begin : g_ctrl
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          ctrl_regs[gi] <= 8'h00;
        end else if (wr_window && (ptr == 5'(gi))) begin
          if (gi == `VRC_IDX_START_HIGH) begin
            ctrl_regs[gi] <= io_req.wdata & `VRC_START_HIGH_MASK;
          end else begin
            ctrl_regs[gi] <= io_req.wdata;
          end
        end
      end
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_state.frame_pulse = 1'b0;
    // MSB goes out first as leftmost pixel.
    next_state.shift = video_memory_cmd.we ? video_memory_cmd.data : 8'h00;
    if (io_req.sel && io_req.wr) begin
      unique case (io_req.port)
        `VRC_PORT_CLEAR_A: next_state.port_a = io_req.wdata;
        `VRC_PORT_LATCH: next_state.latch = io_req.wdata;
        `VRC_PORT_FILL_B: next_state.port_b = io_req.wdata;
        `VRC_PORT_POINTER: next_state.pointer = io_req.wdata[4:0];
        default: next_state.rdata = state.rdata;
      endcase
    end else if (io_req.sel) begin
      unique case (io_req.port)
        `VRC_PORT_CLEAR_A: next_state.rdata = state.port_a;
        `VRC_PORT_LATCH: next_state.rdata = state.latch;
        `VRC_PORT_FILL_B: next_state.rdata = state.port_b;
        `VRC_PORT_POINTER: next_state.rdata = {3'b000, state.pointer};
        `VRC_PORT_WINDOW: begin
          if (32'(state.pointer) < 32'(CTRL_REGS)) begin
            next_state.rdata = ctrl_regs[state.pointer];
          end else begin
            next_state.rdata = 8'h00;
          end
        end
        default: next_state.rdata = 8'h00;
      endcase
    end
    // one frame of scan slots covers the screen.
    if (clear_active) begin
      next_state.fill_run = 1'b1;
      if (frame_end) begin
        next_state.fill_count = 32'h0000_0000;
      end else begin
        next_state.fill_count = state.fill_count + 32'h0000_0001;
      end
    end else begin
      next_state.fill_run = 1'b0;
      next_state.fill_count = 32'h0000_0000;
    end
    if (frame_end) begin
      next_state.frame_pulse = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= '0;
      state.port_a <= `VRC_PORT_A_RESET;
      state.port_b <= `VRC_PORT_B_RESET;
    end else begin
      state <= next_state;
    end
  end
endmodule
